/* File: rtl/fscr_pkg.sv */
/*
  Constants, field layout and types of the frequency-select, identity and
  block-length register bank with its SMBus target.
  Assumes nothing of its surroundings.
*/
package fscr_pkg;
  localparam logic [6:0] SMB_ADDR     = 7'h6d;
  localparam logic [7:0] OFF_FSC      = 8'h03;
  localparam logic [7:0] OFF_RSV      = 8'h04;
  localparam logic [7:0] OFF_REV      = 8'h05;
  localparam logic [7:0] OFF_PART     = 8'h06;
  localparam logic [7:0] OFF_LEN      = 8'h07;
  localparam int         FSC_EN_BIT   = 5;
  localparam int         FSC_SEL_LSB  = 3;
  localparam int         FSC_FB_BIT   = 0;
  localparam logic [7:0] FSC_RSV_ONES = 8'h06;
  localparam logic       FSC_EN_RST   = 1'b0;
  localparam logic [1:0] FSC_SEL_RST  = 2'h0;
  localparam logic       FSC_FB_RST   = 1'b1;
  localparam logic [4:0] LEN_RST      = 5'h08;
  localparam logic [7:0] RSV_BYTE     = 8'hff;
  localparam logic [3:0] BITS_BYTE    = 4'h8;

  typedef struct packed {
    logic       en;
    logic [1:0] fsel;
    logic       fb_fast;
  } fscr_cfg_type;

  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_RACK, ST_TX, ST_TACK, ST_WAIT} fscr_state_type;
  typedef enum logic [1:0] {PH_ADDR, PH_CMD, PH_CNT, PH_DATA} fscr_phase_type;
endpackage

/* File: rtl/fscr_regs.sv */
/*
  SMBus target holding the frequency-select, identity and block-length bytes.
  Assumes SMBus pins and the frequency pins come from outside SYS_CLK; the
  bus wire level is resolved outside from SMB_DATA_OE_N.
*/
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Byte 3 bit 5 enables software frequency changes, reset 0.
// - Byte 3 bits 4:3 select frequency range, ignored unless enable set.
// - Byte 3 bit 0 picks feedback edge rate, 1 fast, reset 1.
// - Byte 4 always reads all ones; writes ignored.
// - Byte 5 reads fixed revision (high nibble) and maker code (low nibble).
// - Byte 6 reads fixed category (bits 7:6) and part code (bits 5:0).
// - Byte 7 bits 4:0 set block read length, reset 8.
// - Byte 3 bits 2:1 read as one; writes have no effect.
// - Block read returns count first, then bytes from offset; host acks, ends nack.
// - Only target address 1101101 is answered, followed by read/write bit.
module fscr_regs
  import fscr_pkg::*;
#(
  parameter logic [3:0] REV_CODE  = 4'h3,  // Arbitrary value
  parameter logic [3:0] MAKER     = 4'h5,  // Arbitrary value
  parameter logic [1:0] CATEGORY  = 2'h2,  // Arbitrary value
  parameter logic [5:0] PART      = 6'h15  // Arbitrary value
) (
  input  wire logic       SYS_CLK,
  input  wire logic       RESET_N,
  input  wire logic       SMB_CLK,
  input  wire logic       SMB_DATA_IN,
  output logic            SMB_DATA_OUT,
  output logic            SMB_DATA_OE_N,
  input  wire logic [1:0] FREQ_SEL_PIN,
  output logic      [1:0] FREQ_RANGE,
  output logic            FB_EDGE_FAST
);

  logic [2:0]     scl_q, sda_q;
  logic [1:0]     pin1_q, pin2_q;
  fscr_state_type state_q, state_d;
  fscr_phase_type ph_q, ph_d;
  fscr_cfg_type   cfg_q, cfg_d;
  logic [4:0]     len_q, len_d;
  logic [7:0]     sr_q, sr_d, tx_q, tx_d, ptr_q, ptr_d;
  logic [3:0]     bit_q, bit_d;
  logic           rd_q, rd_d, first_q, first_d, nack_q, nack_d, drv_q, drv_d;
  logic [1:0]     freq_q, freq_d;
  logic           scl_rise, scl_fall, start_c, stop_c, wr, load;

  function automatic logic [7:0] rd_byte(input logic [7:0] p, input fscr_cfg_type c, input logic [4:0] l);
    logic [7:0] b;
    b = 8'h00;
    case (p)
      OFF_FSC:  b = FSC_RSV_ONES | {2'h0, c.en, c.fsel, 2'h0, c.fb_fast};
      OFF_RSV:  b = RSV_BYTE;
      OFF_REV:  b = {REV_CODE, MAKER};
      OFF_PART: b = {CATEGORY, PART};
      OFF_LEN:  b = {3'h0, l};
      default:  b = 8'h00;
    endcase
    return b;
  endfunction

  // Only the second and third stages feed edge logic; the first is metastable
  assign scl_rise = scl_q[1] & ~scl_q[2];
  assign scl_fall = ~scl_q[1] & scl_q[2];
  assign start_c  = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
  assign stop_c   = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      scl_q  <= 3'h7;
      sda_q  <= 3'h7;
      pin1_q <= 2'h0;
      pin2_q <= 2'h0;
    end else begin
      scl_q  <= {scl_q[1:0], SMB_CLK};
      sda_q  <= {sda_q[1:0], SMB_DATA_IN};
      pin1_q <= FREQ_SEL_PIN;
      pin2_q <= pin1_q;
    end
  end

  always_comb begin
    state_d = state_q;
    ph_d    = ph_q;
    cfg_d   = cfg_q;
    len_d   = len_q;
    sr_d    = sr_q;
    tx_d    = tx_q;
    ptr_d   = ptr_q;
    bit_d   = bit_q;
    rd_d    = rd_q;
    first_d = first_q;
    nack_d  = nack_q;
    wr      = 1'b0;
    load    = 1'b0;
    if (stop_c) begin
      state_d = ST_IDLE;
    end else if (start_c) begin
      state_d = ST_RX;
      ph_d    = PH_ADDR;
      bit_d   = 4'h0;
      rd_d    = 1'b0;
    end else begin
      case (state_q)
        ST_RX: begin
          if (scl_rise) begin
            sr_d  = {sr_q[6:0], sda_q[2]};
            bit_d = bit_q + 4'h1;
          end else if (scl_fall && bit_q == BITS_BYTE) begin
            bit_d   = 4'h0;
            state_d = ST_RACK;
            case (ph_q)
              PH_ADDR: begin
                if (sr_q[7:1] != SMB_ADDR) begin
                  state_d = ST_WAIT;
                end else begin
                  rd_d    = sr_q[0];
                  first_d = 1'b1;
                  ph_d    = sr_q[0] ? PH_DATA : PH_CMD;
                end
              end
              PH_CMD: begin
                ptr_d = sr_q;
                ph_d  = PH_CNT;
              end
              PH_CNT:  ph_d = PH_DATA;
              default: begin
                wr    = 1'b1;
                ptr_d = ptr_q + 8'h01;
              end
            endcase
          end
        end
        ST_RACK: begin
          if (scl_fall) begin
            state_d = rd_q ? ST_TX : ST_RX;
            load    = rd_q;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            bit_d = bit_q + 4'h1;
            if (bit_q == BITS_BYTE - 4'h1) state_d = ST_TACK;
            else tx_d = {tx_q[6:0], 1'b0};
          end
        end
        ST_TACK: begin
          if (scl_rise) nack_d = sda_q[2];
          if (scl_fall) begin
            state_d = nack_q ? ST_WAIT : ST_TX;
            load    = ~nack_q;
          end
        end
        default: ;
      endcase
    end
    if (load) begin
      bit_d = 4'h0;
      if (first_q) begin
        tx_d    = {3'h0, len_q};
        first_d = 1'b0;
      end else begin
        tx_d  = rd_byte(ptr_q, cfg_q, len_q);
        ptr_d = ptr_q + 8'h01;
      end
    end
    if (wr && ptr_q == OFF_FSC) begin
      cfg_d.en      = sr_q[FSC_EN_BIT];
      cfg_d.fsel    = sr_q[FSC_SEL_LSB +: 2];
      cfg_d.fb_fast = sr_q[FSC_FB_BIT];
    end
    if (wr && ptr_q == OFF_LEN) len_d = sr_q[4:0];
    drv_d  = (state_d == ST_RACK) || (state_d == ST_TX && !tx_d[7]);
    freq_d = cfg_q.en ? cfg_q.fsel : pin2_q;
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      state_q <= ST_IDLE;
      ph_q    <= PH_ADDR;
      cfg_q   <= '{en: FSC_EN_RST, fsel: FSC_SEL_RST, fb_fast: FSC_FB_RST};
      len_q   <= LEN_RST;
      sr_q    <= 8'h00;
      tx_q    <= 8'h00;
      ptr_q   <= 8'h00;
      bit_q   <= 4'h0;
      rd_q    <= 1'b0;
      first_q <= 1'b0;
      nack_q  <= 1'b0;
      drv_q   <= 1'b0;
      freq_q  <= FSC_SEL_RST;
    end else begin
      state_q <= state_d;
      ph_q    <= ph_d;
      cfg_q   <= cfg_d;
      len_q   <= len_d;
      sr_q    <= sr_d;
      tx_q    <= tx_d;
      ptr_q   <= ptr_d;
      bit_q   <= bit_d;
      rd_q    <= rd_d;
      first_q <= first_d;
      nack_q  <= nack_d;
      drv_q   <= drv_d;
      freq_q  <= freq_d;
    end
  end

  // Open drain: the line is only ever pulled low, never driven high
  assign SMB_DATA_OUT  = 1'b0;
  assign SMB_DATA_OE_N = ~drv_q;
  assign FREQ_RANGE    = freq_q;
  assign FB_EDGE_FAST  = cfg_q.fb_fast;

  sequence s_addr_read_ack;
    state_q == ST_RACK && ph_q == PH_DATA && first_q && rd_q;
  endsequence

  AST_RESET_VALUES: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    $rose(RESET_N) |-> !cfg_q.en && cfg_q.fsel == FSC_SEL_RST && FB_EDGE_FAST && len_q == LEN_RST)
    else $error("Reset values wrong");
  AST_FREQ_GATE: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    ##1 FREQ_RANGE == ($past(cfg_q.en) ? $past(cfg_q.fsel) : $past(pin2_q)))
    else $error("Frequency range not gated by enable");
  AST_FB_WRITE: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    wr && ptr_q == OFF_FSC |=> FB_EDGE_FAST == $past(sr_q[FSC_FB_BIT]))
    else $error("Feedback edge rate not written");
  AST_RSV_ONES: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    load && !first_q && ptr_q == OFF_RSV |=> tx_q == RSV_BYTE)
    else $error("Reserved byte not all ones");
  AST_REV_MAKER: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    load && !first_q && ptr_q == OFF_REV |=> tx_q == {REV_CODE, MAKER})
    else $error("Revision byte wrong");
  AST_PART: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    load && !first_q && ptr_q == OFF_PART |=> tx_q == {CATEGORY, PART})
    else $error("Part byte wrong");
  AST_LEN_WRITE: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    wr && ptr_q == OFF_LEN |=> len_q == $past(sr_q[4:0]))
    else $error("Block length not written");
  AST_FSC_RSV: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    load && !first_q && ptr_q == OFF_FSC |=> tx_q[2:1] == 2'h3 && tx_q[7:6] == 2'h0)
    else $error("Reserved bits of byte 3 wrong");
  AST_COUNT_FIRST: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    s_addr_read_ack ##0 scl_fall && !stop_c && !start_c |=> state_q == ST_TX && tx_q == {3'h0, len_q})
    else $error("Block read did not start with count");
  AST_ADDR_MATCH: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    $rose(drv_q) && state_q == ST_RACK && $past(ph_q) == PH_ADDR |-> sr_q[7:1] == SMB_ADDR)
    else $error("Acked a foreign address");

endmodule // fscr_regs
`default_nettype wire

/* File: verif/fscr_host.sv */
/*
  SMBus host model that drives the register bank's bus pins.
  Assumes the bench resolves the open-drain data wire with a pull-up.
*/
`timescale 1ns/10ps
`default_nettype none
module fscr_host (
  input  wire logic       sys_clk,
  input  wire logic       sda,
  output logic            scl,
  output logic            sda_host,
  output logic            rx_stb,
  output logic      [7:0] rx_data
);
  initial begin
    scl = 1'b1;
    sda_host = 1'b1;
    rx_stb = 1'b0;
    rx_data = 8'h00;
  end
  // Ten cycles a phase, above the three the synchroniser needs
  task automatic hp();
    repeat (10) @(posedge sys_clk);
    #1;
  endtask
  // Also serves as repeated start, since the clock is low between bytes
  task automatic start_c();
    sda_host = 1'b1;
    hp();
    scl = 1'b1;
    hp();
    sda_host = 1'b0;
    hp();
    scl = 1'b0;
  endtask
  task automatic stop_c();
    sda_host = 1'b0;
    hp();
    scl = 1'b1;
    hp();
    sda_host = 1'b1;
    hp();
  endtask
  task automatic bit_io(input logic b, output logic s);
    sda_host = b;
    hp();
    scl = 1'b1;
    hp();
    s = sda;
    scl = 1'b0;
  endtask
  // Address bytes carry the read/write bit last
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ack_in, ack);
  endtask
  // Acks each byte except the last one, which it nacks
  task automatic rd_byte(input logic last);
    logic [7:0] q;
    logic       a;
    xfer(8'hff, last, q, a);
    rx_data = q;
    rx_stb = 1'b1;
    @(posedge sys_clk);
    #1 rx_stb = 1'b0;
  endtask
endmodule // fscr_host
`default_nettype wire

/* File: verif/fscr_regs_tb.sv */
/*
  Self-checking bench for the register bank, with a host model on the bus.
  Assumes the design package is compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module fscr_regs_tb;
  import fscr_pkg::*;
  localparam logic [3:0] REV   = 4'ha;  // Arbitrary value
  localparam logic [3:0] MAKER = 4'h6;  // Arbitrary value
  localparam logic [1:0] CAT   = 2'h3;  // Arbitrary value
  localparam logic [5:0] PART  = 6'h2b; // Arbitrary value
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  wire logic   sda;
  logic        scl, sda_host, oe_n, d_out, fb_fast, rx_stb;
  logic [1:0]  pin_sel = 2'h0;
  logic [1:0]  range;
  logic [7:0]  rx_data;
  logic [7:0]  shadow [3:7];
  logic [7:0]  wd [5];
  logic [7:0]  exp_q [$];
  logic [15:0] lfsr = 16'h108a;
  int          n_fail = 0;
  int          checks = 0;
  always #12.5 sys_clk = ~sys_clk;
  assign sda = sda_host & (oe_n | d_out);
  fscr_regs #(.REV_CODE(REV), .MAKER(MAKER), .CATEGORY(CAT), .PART(PART)) i_dut (
    .SYS_CLK(sys_clk), .RESET_N(reset_n), .SMB_CLK(scl), .SMB_DATA_IN(sda), .SMB_DATA_OUT(d_out),
    .SMB_DATA_OE_N(oe_n), .FREQ_SEL_PIN(pin_sel), .FREQ_RANGE(range), .FB_EDGE_FAST(fb_fast));
  fscr_host i_host (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_host(sda_host), .rx_stb(rx_stb),
    .rx_data(rx_data));
  function automatic logic [15:0] next_rand(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    checks++;
    if (got !== want) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  // Acks are active low on the wire
  task automatic send(input logic [7:0] d, input logic want_ack);
    logic [7:0] q;
    logic       a;
    i_host.xfer(d, 1'b1, q, a);
    chk({7'h0, a}, {7'h0, ~want_ack});
  endtask
  always @(posedge sys_clk) if (rx_stb) chk(rx_data, exp_q.pop_front());
  task automatic rd_all(input logic [7:0] off);
    i_host.start_c();
    send({SMB_ADDR, 1'b0}, 1'b1);
    send(off, 1'b1);
    i_host.start_c();
    send({SMB_ADDR, 1'b1}, 1'b1);
    exp_q.push_back({3'h0, shadow[7][4:0]});
    for (int k = off; k < 8; k++) exp_q.push_back(shadow[k]);
    for (int k = off; k < 9; k++) i_host.rd_byte(k == 8);
    i_host.stop_c();
  endtask
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // About a sixth of this span is really needed
  initial begin
    #2000000;
    n_fail++;
    stop_test();
  end
  initial begin
    shadow = '{8'h07, RSV_BYTE, {REV, MAKER}, {CAT, PART}, {3'h0, LEN_RST}};
    repeat (12) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1 chk({7'h0, fb_fast}, 8'h01);
    chk({6'h0, range}, 8'h00);
    rd_all(OFF_FSC);
    i_host.start_c();
    send({7'h6c, 1'b0}, 1'b0);
    i_host.stop_c();
    for (int i = 0; i < 4; i++) begin
      for (int k = 0; k < 5; k++) begin
        lfsr = next_rand(lfsr);
        wd[k] = lfsr[7:0];
      end
      wd[0][5] = i[0];
      pin_sel = lfsr[9:8];
      i_host.start_c();
      send({SMB_ADDR, 1'b0}, 1'b1);
      send(OFF_FSC, 1'b1);
      send(8'h05, 1'b1);
      // Bytes 4 to 6 are written too; the device must drop them
      for (int k = 0; k < 5; k++) send(wd[k], 1'b1);
      i_host.stop_c();
      shadow[3] = {2'h0, wd[0][5:3], 2'h3, wd[0][0]};
      shadow[7] = {3'h0, wd[4][4:0]};
      repeat (8) @(posedge sys_clk);
      #1 chk({6'h0, range}, {6'h0, wd[0][5] ? wd[0][4:3] : pin_sel});
      chk({7'h0, fb_fast}, {7'h0, wd[0][0]});
      rd_all(i[1] ? OFF_REV : OFF_FSC);
    end
    stop_test();
  end
endmodule // fscr_regs_tb
`default_nettype wire
